/* logic/vlrx_defs.vh */
// Constants for the VPW single-wire link receiver, error handler and filter.
// Assumes a 50 MHz ref_clk; all symbol times are kept in microseconds.
`ifndef VLRX_DEFS_VH
`define VLRX_DEFS_VH
// Clock rate and microsecond tick
`define VLRX_CLK_MHZ        50
`define VLRX_TICK_CYC       (`VLRX_CLK_MHZ * 1)
// Last count of the tick divider, one below the clock rate in MHz
`define VLRX_TICK_LAST      6'd49
// Receive decode windows at normal speed, microseconds (quad speed uses a quarter, except VLRX_IFS_MIN_US, which is never scaled)
`define VLRX_SHORT_MIN_US   10'd34
`define VLRX_LONG_MIN_US    10'd96
`define VLRX_LONG_MAX_US    10'd163
`define VLRX_SOF_MIN_US     10'd163
`define VLRX_SOF_MAX_US     10'd239
`define VLRX_EOD_MIN_US     10'd163
`define VLRX_EOF_MIN_US     10'd239
`define VLRX_BREAK_MIN_US   10'd240
`define VLRX_IFS_MIN_US     10'd300
// Transmit symbol lengths, microseconds (normal speed only)
`define VLRX_TX_SHORT_US    10'd64
`define VLRX_TX_LONG_US     10'd128
`define VLRX_TX_SOF_US      10'd200
`define VLRX_TX_EOD_US      10'd200
// Receive filter end points and reset values
`define VLRX_FILT_MAX       4'hf
`define VLRX_FILT_MIN       4'h0
`define VLRX_FILT_RESET     4'h0
// Frame check sequence
`define VLRX_CRC_INIT       8'hff
`define VLRX_CRC_POLY       8'h1d
`define VLRX_CRC_GOOD       8'hc4
// State vector codes
`define VLRX_SV_NONE        8'h00
`define VLRX_SV_EOF         8'h08
`define VLRX_SV_RXFULL      8'h0c
`define VLRX_SV_SYMBOL      8'h14
`define VLRX_SV_CRC         8'h18
`define VLRX_SV_QUAD_BREAK  8'h1c
`endif

/* logic/vlrx_core.v */
// VPW link controller core: receive filter, symbol decode, frame receive with
// CRC check, a normal-speed transmitter with echo check, and error handling.
// Assumes one 50 MHz clock, an external transceiver (active bus = high on
// rawReceiveInput and txDrive) and a host that drives the strobes synchronously.
// Function
// - Quad speed received when enabled, never sent
// - Quad traffic ignored while quad disabled
// - Frames of unbounded byte count received
// - Transmitter has no frame length limit
// - Echo error stops driving, flags, interrupts
// - Final remainder not C4 flags CRC error
// - Symbol error while sending means lost arbitration
// - Off-boundary end symbol flags invalid symbol
// - No transmit start while bus held active
// - Shorted-low bus aborts, flags invalid symbol
// - Recovers from bus faults without reset
// - Break flags, waits idle, then SOF
// - State vector read clears pending condition
// - Controller never generates a break symbol
// - Active bus during own end-of-data flags error
// - Sample on rise, count on fall
// - Counter saturates; end points set/clear latch
// - Latch holds until opposite end point
// - Clean edge delayed sixteen and a half to seventeen and a half clocks
// - Too-short pulses past filter flag invalid
// - Break in quad mode loads 1C, exits quad
// - Interrupt only while interrupt enable set
// - CRC polynomial 1D, init all ones
`include "vlrx_defs.vh"
`default_nettype none
module vlrx_core (
  input  wire       ref_clk,
  input  wire       resetn,
  input  wire       rawReceiveInput,
  output reg        txDrive,
  output reg        rxFiltered,
  input  wire [7:0] txData,
  input  wire       txWrite,
  input  wire       txLast,
  output wire       txHoldingEmptyFlag,
  output reg  [7:0] rxData,
  output reg        rxFull,
  output reg  [7:0] stateVector,
  input  wire       svRead,
  input  wire       irqEnableBit,
  output wire       irqRequest,
  input  wire       quadRxEnableWr,
  input  wire       quadRxEnableIn,
  output reg        quadRxEnableFlag
);
  localparam RX_WAITIDLE = 3'b001;
  localparam RX_IDLE     = 3'b010;
  localparam RX_DATA     = 3'b100;
  localparam TX_OFF      = 5'b00001;
  localparam TX_WAIT     = 5'b00010;
  localparam TX_SOF      = 5'b00100;
  localparam TX_BITS     = 5'b01000;
  localparam TX_EOD      = 5'b10000;

  reg       syncA, syncB, sampleReg;
  reg [3:0] filtCnt;
  reg [5:0] tickCnt;
  reg       usTick;
  reg [9:0] symTimer;
  reg       filtPrev;
  reg [2:0] rxState;
  reg       quadMode, frameOpen, errWait;
  reg [2:0] rxBitCnt;
  reg [6:0] rxShift;
  reg [7:0] rxCrc;
  reg       rxGotByte;
  reg [4:0] txState;
  reg [7:0] txHold;
  reg       txHoldLast, txHoldFull;
  reg [7:0] txShift, txCrc;
  reg [2:0] txBitIdx;
  reg       txByteLast, txSendingCrc;
  reg [9:0] txTimer, txLen;

  // Bit update of the frame check sequence, shared by both directions
  function [7:0] crcBit;
    input [7:0] crc;
    input       b;
    begin
      crcBit = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? `VLRX_CRC_POLY : 8'h00);
    end
  endfunction

  // Quad-speed windows are a quarter of the normal ones
  function [9:0] thr;
    input [9:0] v;
    input       q;
    begin
      thr = q ? {2'b00, v[9:2]} : v;
    end
  endfunction

  // Pin synchroniser, then the filter sample on the rising edge
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      syncA     <= 1'b0;
      syncB     <= 1'b0;
      sampleReg <= 1'b0;
    end else begin
      syncA     <= rawReceiveInput;
      syncB     <= syncA;
      sampleReg <= syncB;
    end
  end

  // Saturating up/down counter on the falling edge; latch moves only at the
  // end points, so pulses under fifteen clocks never reach the decoder
  always @(negedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      filtCnt    <= `VLRX_FILT_RESET;
      rxFiltered <= 1'b0;
    end else begin
      if (sampleReg && filtCnt != `VLRX_FILT_MAX) begin
        filtCnt <= filtCnt + 4'h1;
      end else if (!sampleReg && filtCnt != `VLRX_FILT_MIN) begin
        filtCnt <= filtCnt - 4'h1;
      end
      if (sampleReg && filtCnt == `VLRX_FILT_MAX - 4'h1) begin
        rxFiltered <= 1'b1;
      end else if (!sampleReg && filtCnt == `VLRX_FILT_MIN + 4'h1) begin
        rxFiltered <= 1'b0;
      end
    end
  end

  wire rxEdge  = rxFiltered != filtPrev;
  wire txBusy  = (txState == TX_SOF) || (txState == TX_BITS) || (txState == TX_EOD);
  wire busIdle = !rxFiltered && (symTimer >= `VLRX_IFS_MIN_US);
  wire txEnd   = usTick && (txTimer + 10'd1 >= txLen);
  wire txBitNow = txShift[txBitIdx];
  // Remainder including the bit now ending, so the appended CRC covers it
  wire [7:0] txCrcNext = crcBit(txCrc, txBitNow);

  // Receive-side event decode, combinational so both state machines see it
  reg       evByte, evSym, evCrc, evBreak, evSof, evSofQuad, evEof, evTxErr;
  reg       bitVal, lenOk;
  always @* begin
    evByte    = 1'b0;
    evSym     = 1'b0;
    evCrc     = 1'b0;
    evBreak   = 1'b0;
    evSof     = 1'b0;
    evSofQuad = 1'b0;
    evEof     = 1'b0;
    lenOk     = (symTimer >= thr(`VLRX_SHORT_MIN_US, quadMode)) &&
                (symTimer <  thr(`VLRX_LONG_MAX_US, quadMode));
    bitVal    = (symTimer < thr(`VLRX_LONG_MIN_US, quadMode)) ^ !filtPrev;
    case (rxState)
      RX_IDLE: begin
        if (rxEdge && filtPrev && symTimer >= `VLRX_SOF_MIN_US &&
            symTimer < `VLRX_SOF_MAX_US) begin
          evSof = 1'b1;
        end else if (rxEdge && filtPrev && quadRxEnableFlag &&
                     symTimer >= thr(`VLRX_SOF_MIN_US, 1'b1) &&
                     symTimer <  thr(`VLRX_SOF_MAX_US, 1'b1)) begin
          evSofQuad = 1'b1;
        end
        evEof = frameOpen && !rxFiltered && symTimer == thr(`VLRX_EOF_MIN_US, quadMode);
      end
      RX_DATA: begin
        if (rxFiltered && symTimer >= thr(`VLRX_BREAK_MIN_US, quadMode)) begin
          evBreak = 1'b1;
        end else if (!rxFiltered && symTimer >= thr(`VLRX_EOD_MIN_US, quadMode)) begin
          if (rxBitCnt != 3'd0 || !rxGotByte) begin
            evSym = 1'b1;
          end else if (rxCrc != `VLRX_CRC_GOOD) begin
            evCrc = 1'b1;
          end
        end else if (rxEdge && !lenOk) begin
          evSym = 1'b1;
        end else if (rxEdge && rxBitCnt == 3'd7) begin
          evByte = 1'b1;
        end
      end
      default: begin
        evSym = 1'b0;
      end
    endcase
    // Echo mismatch while we drive active, or active bus during our EOD
    evTxErr = (txState == TX_BITS || txState == TX_SOF) && txEnd && txDrive &&
              !rxFiltered;
    if (txState == TX_EOD && rxFiltered) begin
      evTxErr = 1'b1;
    end
  end

  // Microsecond tick and time since the last filtered edge
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tickCnt  <= 6'h00;
      usTick   <= 1'b0;
      symTimer <= 10'h000;
      filtPrev <= 1'b0;
    end else begin
      usTick   <= (tickCnt == `VLRX_TICK_LAST);
      tickCnt  <= (tickCnt == `VLRX_TICK_LAST) ? 6'h00 : tickCnt + 6'h01;
      filtPrev <= rxFiltered;
      if (rxEdge) begin
        symTimer <= 10'h000;
      end else if (usTick && symTimer != 10'h3ff) begin
        symTimer <= symTimer + 10'h001;
      end
    end
  end

  // Receive state machine, state vector and quad enable
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rxState          <= RX_WAITIDLE;
      quadMode         <= 1'b0;
      frameOpen        <= 1'b0;
      errWait          <= 1'b0;
      rxBitCnt         <= 3'd0;
      rxShift          <= 7'h00;
      rxCrc            <= `VLRX_CRC_INIT;
      rxGotByte        <= 1'b0;
      rxData           <= 8'h00;
      rxFull           <= 1'b0;
      stateVector      <= `VLRX_SV_NONE;
      quadRxEnableFlag <= 1'b0;
    end else begin
      rxFull <= 1'b0;
      // A read clears; any event in the same cycle overwrites below
      if (svRead) begin
        stateVector <= `VLRX_SV_NONE;
      end
      if (quadRxEnableWr) begin
        quadRxEnableFlag <= quadRxEnableIn;
      end
      // Our own start of frame ends the wait after an earlier error
      if (txState == TX_SOF) begin
        errWait <= 1'b0;
      end
      case (rxState)
        RX_WAITIDLE: begin
          if (busIdle) begin
            rxState <= RX_IDLE;
          end
        end
        RX_IDLE: begin
          if (evSof || evSofQuad) begin
            rxState   <= RX_DATA;
            quadMode  <= evSofQuad;
            frameOpen <= 1'b1;
            errWait   <= 1'b0;
            rxBitCnt  <= 3'd0;
            rxCrc     <= `VLRX_CRC_INIT;
            rxGotByte <= 1'b0;
          end
          if (evEof) begin
            frameOpen   <= 1'b0;
            stateVector <= `VLRX_SV_EOF;
          end
        end
        RX_DATA: begin
          if (evBreak) begin
            rxState <= RX_WAITIDLE;
            errWait <= 1'b1;
            if (quadMode) begin
              stateVector      <= `VLRX_SV_QUAD_BREAK;
              quadRxEnableFlag <= 1'b0;
              quadMode         <= 1'b0;
            end else begin
              stateVector <= `VLRX_SV_SYMBOL;
            end
          end else if (evSym || evCrc) begin
            rxState     <= RX_IDLE;
            errWait     <= 1'b1;
            frameOpen   <= 1'b0; // No end-of-frame code over the error
            stateVector <= evCrc ? `VLRX_SV_CRC : `VLRX_SV_SYMBOL;
          end else if (!rxFiltered && symTimer >= thr(`VLRX_EOD_MIN_US, quadMode)) begin
            rxState <= RX_IDLE;
          end else if (rxEdge) begin
            rxCrc    <= crcBit(rxCrc, bitVal);
            rxShift  <= {rxShift[5:0], bitVal};
            rxBitCnt <= rxBitCnt + 3'd1;
            if (evByte) begin
              rxData    <= {rxShift, bitVal};
              rxFull    <= 1'b1;
              rxGotByte <= 1'b1;
              if (stateVector == `VLRX_SV_NONE || svRead) begin
                stateVector <= `VLRX_SV_RXFULL;
              end
            end
          end
        end
        default: begin
          rxState <= RX_WAITIDLE;
        end
      endcase
      // Transmit-side errors, dropped while already awaiting SOF after one
      if (evTxErr && !errWait && !evBreak) begin
        stateVector <= `VLRX_SV_SYMBOL;
        errWait     <= 1'b1;
        rxState     <= RX_IDLE;
      end
    end
  end

  // Interrupt request gated by the enable bit
  assign irqRequest         = irqEnableBit && (stateVector != `VLRX_SV_NONE);
  assign txHoldingEmptyFlag = !txHoldFull;

  // Transmitter: normal speed only, and never holds active beyond SOF length,
  // so it cannot produce a break symbol
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txState      <= TX_OFF;
      txDrive      <= 1'b0;
      txHold       <= 8'h00;
      txHoldLast   <= 1'b0;
      txHoldFull   <= 1'b0;
      txShift      <= 8'h00;
      txCrc        <= `VLRX_CRC_INIT;
      txBitIdx     <= 3'd7;
      txByteLast   <= 1'b0;
      txSendingCrc <= 1'b0;
      txTimer      <= 10'h000;
      txLen        <= `VLRX_TX_SOF_US;
    end else begin
      if (usTick) begin
        txTimer <= txTimer + 10'h001;
      end
      case (txState)
        TX_OFF: begin
          txDrive <= 1'b0;
          if (txHoldFull) begin
            txState <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (busIdle && rxState != RX_DATA) begin
            txState <= TX_SOF;
            txDrive <= 1'b1;
            txTimer <= 10'h000;
            txLen   <= `VLRX_TX_SOF_US;
            txCrc   <= `VLRX_CRC_INIT;
          end
        end
        TX_SOF, TX_BITS: begin
          if (evTxErr || evBreak) begin
            txState    <= TX_OFF;
            txDrive    <= 1'b0;
            txHoldFull <= 1'b0;
          end else if (evSym || (txEnd && !txDrive && rxFiltered)) begin
            txState <= TX_OFF;
            txDrive <= 1'b0;
          end else if (txEnd) begin
            txTimer <= 10'h000;
            if (txState == TX_SOF || txBitIdx == 3'd0) begin
              if (txState == TX_BITS && txSendingCrc) begin
                txState <= TX_EOD;
                txDrive <= 1'b0;
                txLen   <= `VLRX_TX_EOD_US;
              end else if (txState == TX_BITS && txByteLast) begin
                txState      <= TX_BITS;
                txSendingCrc <= 1'b1;
                txShift      <= ~txCrcNext;
                txBitIdx     <= 3'd7;
                txDrive      <= 1'b0;
                txLen        <= txCrcNext[7] ? `VLRX_TX_SHORT_US : `VLRX_TX_LONG_US;
              end else if (txHoldFull) begin
                txState      <= TX_BITS;
                txShift      <= txHold;
                txByteLast   <= txHoldLast;
                txHoldFull   <= 1'b0;
                txSendingCrc <= 1'b0;
                txBitIdx     <= 3'd7;
                txDrive      <= 1'b0;
                txLen        <= txHold[7] ? `VLRX_TX_LONG_US : `VLRX_TX_SHORT_US;
              end else begin
                txState <= TX_OFF; // Underrun ends the frame on a byte boundary, with no CRC byte
                txDrive <= 1'b0;
              end
              if (txState == TX_BITS && !txSendingCrc) begin
                txCrc <= crcBit(txCrc, txBitNow);
              end
            end else begin
              txCrc    <= txSendingCrc ? txCrc : crcBit(txCrc, txBitNow);
              txBitIdx <= txBitIdx - 3'd1;
              txDrive  <= !txDrive;
              txLen    <= (txShift[txBitIdx - 3'd1] ^ !txDrive) ? `VLRX_TX_LONG_US :
                          `VLRX_TX_SHORT_US;
            end
          end
        end
        TX_EOD: begin
          if (evTxErr || txEnd) begin
            txState <= TX_OFF;
          end
        end
        default: begin
          txState <= TX_OFF;
          txDrive <= 1'b0;
        end
      endcase
      // Host write last, so a byte written as an abort clears the hold still lands
      if (txWrite && !txHoldFull) begin
        txHold     <= txData;
        txHoldLast <= txLast;
        txHoldFull <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/vlrx_core_sva.sv */
// Concurrent checks on the ports of the link core.
// Assumes a bind into vlrx_core; active bus is high on both bus pins.
`default_nettype none
module vlrx_core_sva (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       rawReceiveInput,
  input wire logic       txDrive,
  input wire logic       rxFiltered,
  input wire logic       txWrite,
  input wire logic       txHoldingEmptyFlag,
  input wire logic       rxFull,
  input wire logic [7:0] stateVector,
  input wire logic       svRead,
  input wire logic       irqEnableBit,
  input wire logic       irqRequest,
  input wire logic       quadRxEnableFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] highRun;
  logic [15:0] lowRun;
  logic [15:0] driveRun;
  // Saturating run lengths; counters avoid huge repetition counts
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      highRun  <= 16'h0000;
      lowRun   <= 16'h0000;
      driveRun <= 16'h0000;
    end else begin
      highRun  <= rawReceiveInput ? highRun + {15'h0000, ~&highRun} : 16'h0000;
      lowRun   <= !rawReceiveInput ? lowRun + {15'h0000, ~&lowRun} : 16'h0000;
      driveRun <= txDrive ? driveRun + {15'h0000, ~&driveRun} : 16'h0000;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Steps of the quad break and of a host write
  sequence sqBreakLoaded;
    stateVector == 8'h1c && $past(stateVector) != 8'h1c;
  endsequence
  sequence sqHostWrite;
    txWrite && txHoldingEmptyFlag;
  endsequence
  a_filter_rise_max: assert property (highRun == 16'h0014 |-> rxFiltered)
    else $error("filter output not high after clean rise");
  a_filter_fall_max: assert property (lowRun == 16'h0014 |-> !rxFiltered)
    else $error("filter output not low after clean fall");
  a_irq_masked: assert property (!irqEnableBit |-> !irqRequest)
    else $error("interrupt while disabled");
  a_irq_pending: assert property (irqEnableBit && stateVector != 8'h00 |-> irqRequest)
    else $error("pending event without interrupt");
  a_break_read_clear: assert property (svRead && stateVector == 8'h1c |=> stateVector == 8'h00)
    else $error("read did not clear break code");
  a_quad_break_exit: assert property (sqBreakLoaded |-> ##[0:1] !quadRxEnableFlag)
    else $error("quad mode kept after break");
  a_hold_write_ack: assert property (sqHostWrite |=> !txHoldingEmptyFlag)
    else $error("host byte not taken");
  a_no_break_drive: assert property (driveRun < 16'h2ee0)
    else $error("active drive as long as a break");
  a_start_after_idle: assert property ($rose(txDrive) |-> lowRun >= 16'h03e8)
    else $error("drive started on a busy bus");
  a_rx_byte_pulse: assert property (rxFull |=> !rxFull)
    else $error("byte flag longer than one cycle");
  cover property (sqBreakLoaded);
endmodule
bind vlrx_core vlrx_core_sva u_sva (.ref_clk(ref_clk), .resetn(resetn),
  .rawReceiveInput(rawReceiveInput), .txDrive(txDrive), .rxFiltered(rxFiltered),
  .txWrite(txWrite), .txHoldingEmptyFlag(txHoldingEmptyFlag), .rxFull(rxFull),
  .stateVector(stateVector), .svRead(svRead), .irqEnableBit(irqEnableBit),
  .irqRequest(irqRequest), .quadRxEnableFlag(quadRxEnableFlag));
`default_nettype wire

/* dv/vlrx_node_model.sv */
// Behavioural model of another node on the shared single-wire bus.
// Assumes the bench merges nodeDrive into the bus; high is active, pulled low.
`default_nettype none
module vlrx_node_model (
  input wire logic ref_clk,
  output var logic nodeDrive
);
  timeunit 1ns;
  timeprecision 1ps;
  initial nodeDrive = 1'b0;
  // One level for n clocks, changed just after a rising edge
  task automatic holdCycles(input logic lvl, input int n);
    @(posedge ref_clk);
    #1 nodeDrive = lvl;
    repeat (n - 1) @(posedge ref_clk);
  endtask
  // Levels alternate from passive; long when value and level differ
  task automatic sendByte(input logic [7:0] b, input int div);
    logic lvl;
    for (int i = 7; i >= 0; i--) begin
      lvl = ~i[0];
      holdCycles(lvl, ((b[i] ^ lvl) ? 128 : 64) * 50 / div);
    end
  endtask
  // Start symbol, bytes MSB first, then a passive tail past end of frame
  task automatic sendFrame(input logic [7:0] b0, input logic [7:0] b1, input int n,
                           input int div);
    holdCycles(1'b1, 200 * 50 / div);
    sendByte(b0, div);
    if (n > 1) sendByte(b1, div);
    holdCycles(1'b0, 280 * 50 / div);
  endtask
  // Active period well beyond the break threshold
  task automatic sendBreak(input int div);
    holdCycles(1'b1, 520 * 50 / div);
    holdCycles(1'b0, 50);
  endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the link core with one remote node model.
// Assumes bus faults are modelled here: shorts override every driver.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0, resetn = 1'b0, shortBatt = 1'b0, shortGnd = 1'b0;
  logic       txWrite = 1'b0, txLast = 1'b0, svRead = 1'b0, irqEnableBit = 1'b0;
  logic       quadRxEnableWr = 1'b0, quadRxEnableIn = 1'b0, autoAck = 1'b0;
  logic       txSeen = 1'b0, crcSeen = 1'b0;
  logic [7:0] txData = 8'h00, rxFirst;
  logic       nodeDrive, txDrive, rxFiltered, txHoldingEmptyFlag, rxFull, irqRequest;
  logic       quadRxEnableFlag;
  logic [7:0] rxData, stateVector;
  wire        rawReceiveInput;
  int         err_count = 0, total_checks = 0, cycles = 0, rxCount = 0;
  // Wired bus: a short wins over any driver
  assign rawReceiveInput = !shortGnd && (shortBatt || txDrive || nodeDrive);
  always #10 ref_clk = ~ref_clk;
  vlrx_core DUT (.ref_clk(ref_clk), .resetn(resetn), .rawReceiveInput(rawReceiveInput),
    .txDrive(txDrive), .rxFiltered(rxFiltered), .txData(txData), .txWrite(txWrite),
    .txLast(txLast), .txHoldingEmptyFlag(txHoldingEmptyFlag), .rxData(rxData),
    .rxFull(rxFull), .stateVector(stateVector), .svRead(svRead),
    .irqEnableBit(irqEnableBit), .irqRequest(irqRequest), .quadRxEnableWr(quadRxEnableWr),
    .quadRxEnableIn(quadRxEnableIn), .quadRxEnableFlag(quadRxEnableFlag));
  vlrx_node_model node (.ref_clk(ref_clk), .nodeDrive(nodeDrive));
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Sample after the edge has settled
  task automatic step();
    @(posedge ref_clk);
    #2;
  endtask
  task automatic readSv();
    @(posedge ref_clk);
    #1 svRead = 1'b1;
    @(posedge ref_clk);
    #1 svRead = 1'b0;
  endtask
  // Reference remainder step, MSB first, divisor 1d
  function automatic logic [7:0] crcByte(input logic [7:0] r, input logic [7:0] d);
    logic [7:0] c;
    c = r ^ d;
    for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h1d : {c[6:0], 1'b0};
    return c;
  endfunction
  // Monitors and the hang limit
  always @(posedge ref_clk) begin
    if (rxFull === 1'b1) begin
      if (rxCount == 0) rxFirst = rxData;
      rxCount++;
    end
    if (txDrive === 1'b1) txSeen = 1'b1;
    if (stateVector === 8'h18) crcSeen = 1'b1;
    cycles++;
    if (cycles == 120000) begin
      err_count++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      conclude();
    end
  end
  // Host acknowledges each received byte while a frame is expected
  always begin
    @(posedge ref_clk);
    if (autoAck && rxFull === 1'b1) begin
      #1 svRead = 1'b1;
      @(posedge ref_clk);
      #1 svRead = 1'b0;
    end
  end
  task automatic filterEdge(input logic lvl, output int n);
    fork node.holdCycles(lvl, 60); join_none
    @(posedge ref_clk);
    for (n = 0; n < 40 && rxFiltered !== lvl; n++) step();
    wait fork;
  endtask
  task automatic testFilter();
    int n;
    check(rxFiltered === 1'b0, "filter reset level");
    node.holdCycles(1'b1, 8);
    node.holdCycles(1'b0, 30);
    check(rxFiltered === 1'b0, "short pulse passed");
    filterEdge(1'b1, n);
    check(n >= 16 && n <= 19, "rise delay");
    node.holdCycles(1'b0, 8);
    node.holdCycles(1'b1, 30);
    check(rxFiltered === 1'b1, "latch lost on dip");
    filterEdge(1'b0, n);
    check(n >= 16 && n <= 19, "fall delay after saturation");
    $display("filter test done");
  endtask
  task automatic testQuadOff();
    rxCount = 0;
    node.sendFrame(8'h55, 8'h00, 1, 4);
    check(rxCount == 0, "quad frame taken while disabled");
    $display("quad off test done");
  endtask
  task automatic testQuadGood();
    int n;
    readSv();
    @(posedge ref_clk);
    #1 quadRxEnableWr = 1'b1;
    quadRxEnableIn = 1'b1;
    @(posedge ref_clk);
    #1 quadRxEnableWr = 1'b0;
    step();
    check(quadRxEnableFlag === 1'b1, "quad enable write");
    rxCount = 0;
    crcSeen = 1'b0;
    autoAck = 1'b1;
    node.sendFrame(8'h55, ~crcByte(8'hff, 8'h55), 2, 4);
    check(rxCount == 2 && rxFirst === 8'h55, "quad byte");
    for (n = 0; n < 5000 && stateVector !== 8'h08; n++) step();
    check(stateVector === 8'h08 && !crcSeen, "good frame end");
    autoAck = 1'b0;
    readSv();
    $display("quad frame test done");
  endtask
  task automatic testCrcError();
    int n;
    autoAck = 1'b1;
    node.sendFrame(8'h55, 8'h00, 1, 4);
    for (n = 0; n < 5000 && stateVector !== 8'h18; n++) step();
    check(stateVector === 8'h18, "crc error code");
    check(irqRequest === 1'b0, "interrupt while disabled");
    @(posedge ref_clk);
    #1 irqEnableBit = 1'b1;
    step();
    check(irqRequest === 1'b1, "crc interrupt");
    autoAck = 1'b0;
    readSv();
    $display("crc test done");
  endtask
  task automatic testBreak();
    int n;
    node.holdCycles(1'b1, 2500); // Quad start, then one passive bit
    node.holdCycles(1'b0, 800);
    node.sendBreak(4);
    for (n = 0; n < 2000 && stateVector !== 8'h1c; n++) step();
    check(stateVector === 8'h1c, "quad break code");
    check(quadRxEnableFlag === 1'b0, "quad mode kept");
    check(irqRequest === 1'b1, "break interrupt");
    readSv();
    step();
    check(stateVector === 8'h00, "read did not clear");
    $display("break test done");
  endtask
  task automatic testTxFault();
    int n;
    @(posedge ref_clk);
    #1 shortBatt = 1'b1;
    txSeen = 1'b0;
    for (n = 0; n < 100 && txHoldingEmptyFlag !== 1'b1; n++) step();
    @(posedge ref_clk);
    #1 txData = 8'h55;
    txLast = 1'b1;
    txWrite = 1'b1;
    @(posedge ref_clk);
    #1 txWrite = 1'b0;
    step();
    check(txHoldingEmptyFlag === 1'b0, "byte not taken");
    repeat (1500) step();
    check(txSeen === 1'b0, "sent onto active bus");
    @(posedge ref_clk);
    #1 shortBatt = 1'b0;
    readSv();
    for (n = 0; n < 40000 && txDrive !== 1'b1; n++) step();
    check(txDrive === 1'b1, "no start after fault cleared");
    @(posedge ref_clk);
    #1 shortGnd = 1'b1;
    for (n = 0; n < 12000 && txDrive !== 1'b0; n++) step();
    check(txDrive === 1'b0, "drive not stopped");
    for (n = 0; n < 2000 && stateVector !== 8'h14; n++) step();
    check(stateVector === 8'h14 && irqRequest === 1'b1, "fault code");
    @(posedge ref_clk);
    #1 shortGnd = 1'b0;
    $display("transmit fault test done");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 resetn = 1'b1;
    testFilter();
    repeat (15500) @(posedge ref_clk);
    testQuadOff();
    repeat (500) @(posedge ref_clk);
    testQuadGood();
    repeat (500) @(posedge ref_clk);
    testCrcError();
    repeat (500) @(posedge ref_clk);
    testBreak();
    testTxFault();
    conclude();
  end
endmodule
`default_nettype wire
